// file: design/igcc_pkg.sv
package igcc_pkg;
    // timing base
    localparam int CLK_KHZ  = 100000;
    localparam int MOD_KHZ  = 1280;
    localparam int OSR      = 64;
    localparam int PH_W     = 17;
    localparam int HOLD_LONG_US  = 50000;
    localparam int HOLD_SHORT_US = 25000;
    localparam int HOLD_LONG_TICKS  = HOLD_LONG_US * MOD_KHZ / 1000;
    localparam int HOLD_SHORT_TICKS = HOLD_SHORT_US * MOD_KHZ / 1000;
    // gain code: 0.5 dB steps spanning -1 dB to 40 dB
    localparam int GAIN_W = 7;
    localparam logic [6:0] GAIN_MIN_CODE = 7'h00;
    localparam logic [6:0] GAIN_MAX_CODE = 7'h52;
    // register map (3-bit address, 0 means no access)
    localparam logic [2:0] A_PWR  = 3'h1;
    localparam logic [2:0] A_GAIN = 3'h2;
    localparam logic [2:0] A_FAR  = 3'h3;
    localparam logic [2:0] A_FMT1 = 3'h4;
    localparam logic [2:0] A_FMT4 = 3'h5;
    localparam logic [7:0] PWR_RST  = 8'h00;
    localparam logic [7:0] GAIN_RST = 8'h52;
    localparam logic [7:0] FAR_RST  = 8'h00;
    localparam logic [7:0] FMT1_RST = 8'h00;
    localparam logic [7:0] FMT4_RST = 8'h55;
    localparam logic [7:0] PWR_MASK  = 8'h1C;
    localparam logic [7:0] AR_MASK   = 8'h77;
    localparam logic [7:0] FMT1_MASK = 8'h03;
    // field positions
    localparam int MODE_LSB = 2;
    localparam int HOLD_BIT = 4;
    localparam int RDBK_BIT = 7;
    localparam int ATT_LSB  = 0;
    localparam int REL_LSB  = 4;
    // high-pass selections and leak shifts
    localparam logic [1:0] HPF_50  = 2'h0;
    localparam logic [1:0] HPF_100 = 2'h1;
    localparam int HPF_SH_50  = 7;
    localparam int HPF_SH_100 = 6;
    localparam int HPF_FRAC   = 8;

    typedef enum logic [1:0] {
        MODE_DUAL, MODE_SINGLE, MODE_FIXED_STEP, MODE_FIXED_IMM
    } igcc_mode_t;

    // step every (8 << sel) modulator ticks; sel 0 gives 80 dB/ms
    function automatic logic rate_hit(input logic [15:0] presc,
                                      input logic [2:0] sel);
        logic [15:0] mask;
        mask = (16'h0008 << sel) - 16'h0001;
        return &(presc | ~mask);
    endfunction : rate_hit

    function automatic logic [6:0] gmin(input logic [6:0] a,
                                        input logic [6:0] b);
        return (a < b) ? a : b;
    endfunction : gmin
endpackage : igcc_pkg

// file: design/igcc_ctr_if.sv
`timescale 1ns/1ns
// control and state of one gain counter
interface igcc_ctr_if;
    logic       dec;
    logic       inc;
    logic       load;
    logic [6:0] target;
    logic [6:0] max;
    logic [6:0] code;
    modport ctl (output dec, inc, load, target, max, input code);
    modport ctr (input dec, inc, load, target, max, output code);
endinterface : igcc_ctr_if

// file: design/igcc_gain_ctr.sv
`timescale 1ns/1ns
module igcc_gain_ctr (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic clk_en,
    igcc_ctr_if.ctr  bus
);
    typedef struct packed {
        logic [6:0] code;
    } igcc_ctr_st_t;

    igcc_ctr_st_t st_reg;
    igcc_ctr_st_t st_next;

    // load wins, then clamp, then single steps; never wraps
    always_comb begin
        st_next = st_reg;
        if (bus.load) begin
            st_next.code = bus.target;
        end else if (st_reg.code > bus.max) begin
            st_next.code = bus.max;
        end else if (bus.dec && st_reg.code != igcc_pkg::GAIN_MIN_CODE) begin
            st_next.code = st_reg.code - 7'h01;
        end else if (bus.inc && st_reg.code < bus.max) begin
            st_next.code = st_reg.code + 7'h01;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            st_reg <= '{code: igcc_pkg::GAIN_MAX_CODE};
        end else if (clk_en) begin
            st_reg <= st_next;
        end
    end

    assign bus.code = st_reg.code;
endmodule : igcc_gain_ctr

// file: design/igcc_hpf.sv
`timescale 1ns/1ns
module igcc_hpf (
    input  wire logic        clk_sys,
    input  wire logic        rst,
    input  wire logic        clk_en,
    input  wire logic        in_valid,
    input  wire logic [15:0] in_sample,
    input  wire logic [1:0]  sel,
    output logic             out_valid,
    output logic [15:0]      out_sample
);
    typedef struct packed {
        logic [15:0] xprev;
        logic [25:0] acc;
        logic [15:0] y;
        logic        vld;
    } igcc_hpf_st_t;

    igcc_hpf_st_t st_reg;
    igcc_hpf_st_t st_next;

    function automatic logic [15:0] sat16(input logic signed [25:0] v);
        if (v > 26'sh0007FFF) return 16'h7FFF;
        if (v < -26'sh0008000) return 16'h8000;
        return v[15:0];
    endfunction : sat16

    // y = x - x1 + (1 - 2^-k) y1, kept with 8 fraction bits
    always_comb begin
        logic signed [16:0] diff;
        logic signed [25:0] acc_n;
        logic [2:0]         sh;
        diff  = 17'($signed(in_sample)) - 17'($signed(st_reg.xprev));
        sh    = (sel == igcc_pkg::HPF_100) ? 3'(igcc_pkg::HPF_SH_100)
                                           : 3'(igcc_pkg::HPF_SH_50);
        acc_n = $signed(st_reg.acc) + (26'(diff) <<< igcc_pkg::HPF_FRAC)
              - ($signed(st_reg.acc) >>> sh);
        st_next     = st_reg;
        st_next.vld = in_valid;
        if (in_valid) begin
            st_next.xprev = in_sample;
            if (sel[1]) begin
                st_next.acc = '0;
                st_next.y   = in_sample;
            end else begin
                st_next.acc = acc_n;
                st_next.y   = sat16(acc_n >>> igcc_pkg::HPF_FRAC);
            end
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            st_reg <= '0;
        end else if (clk_en) begin
            st_reg <= st_next;
        end
    end

    assign out_valid  = st_reg.vld;
    assign out_sample = st_reg.y;
endmodule : igcc_hpf

// file: design/igcc_top.sv
// Local design decisions: the strobed register port and the placing of the registers.
`timescale 1ns/1ns
// Overview of operation
// - compressor mode from power control bits 3:2; dual-rate after reset.
// - automatic modes step fast counter down while above upper threshold.
// - automatic modes step fast counter up below lower threshold, capped.
// - increase only after hold time below lower threshold: 50 or 25 ms.
// - dual-rate slow counter tracks fast counter at slow rates.
// - dual-rate applied gain is smaller of the two counters.
// - rates come from fast and format-four registers as clock selects.
// - single-rate mode uses fast counter alone; slow counter never steps, only clamps to a lowered setting.
// - fixed stepped mode walks gain to setting at fast rates.
// - fixed immediate mode loads the gain setting at once.
// - gain register bit 7 selects readback of applied gain.
// - stepped moves pass every 0.5 dB step, fastest 80 dB/ms.
// - rate and hold timing derive from a 1.28 MHz tick.
// - gain codes span -1 dB to 40 dB.
// - one sample per 64 modulator ticks, 20 kHz.
// - samples are 16-bit two's complement.
// - high-pass 50 Hz, 100 Hz or bypass; 50 Hz after reset.
// - power-down input stops analog and holds gain, sample and read outputs low.
// - one output serves as external reset and low-battery flag.
// - unused register bits always read zero.
module igcc_top #(
    parameter logic [15:0] HOLD_LONG_TICKS  = 16'(igcc_pkg::HOLD_LONG_TICKS),
    parameter logic [15:0] HOLD_SHORT_TICKS = 16'(igcc_pkg::HOLD_SHORT_TICKS)
) (
    input  wire logic        clk_sys,
    input  wire logic        rst,
    input  wire logic        clk_en,
    input  wire logic [2:0]  reg_addr,
    input  wire logic [7:0]  reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [7:0]  reg_rdata,
    input  wire logic        cmp_above_upper_in,
    input  wire logic        cmp_below_lower_in,
    input  wire logic        ext_powerdown_in,
    input  wire logic        low_batt_in,
    input  wire logic [15:0] adc_raw_in,
    output logic      [6:0]  gain_code_out,
    output logic             analog_pd_out,
    output logic             reset_lowbatt_out,
    output logic      [15:0] sample_out,
    output logic             sample_valid_out
);
    // ****************************************************
    // state
    // ****************************************************
    typedef struct packed {
        logic [7:0]  pwr;
        logic [7:0]  gain;
        logic [7:0]  far;
        logic [7:0]  fmt1;
        logic [7:0]  fmt4;
        logic [1:0]  up_s;
        logic [1:0]  lo_s;
        logic [1:0]  pd_s;
        logic [1:0]  lb_s;
        logic [16:0] ph;
        logic [15:0] presc;
        logic [5:0]  dec_cnt;
        logic [15:0] hold;
        logic [6:0]  gain_out;
        logic [7:0]  rdata;
        logic        pd_out;
        logic        rl_out;
        logic [15:0] smp;
        logic        svld;
    } igcc_top_st_t;

    igcc_top_st_t st_reg;
    igcc_top_st_t st_next;

    igcc_ctr_if fast_if ();
    igcc_ctr_if slow_if ();

    igcc_pkg::igcc_mode_t mode;
    logic        above;
    logic        below;
    logic        pd;
    logic        tick;
    logic        take;
    logic        auto_md;
    logic [6:0]  cap;
    logic [6:0]  applied;
    logic [15:0] hold_lim;
    logic        hold_done;
    logic        f_att;
    logic        f_rel;
    logic        s_att;
    logic        s_rel;
    logic        hpf_vld;
    logic [15:0] hpf_smp;

    // ****************************************************
    // decoded controls
    // ****************************************************
    // mode field
    assign mode    = igcc_pkg::igcc_mode_t'(st_reg.pwr[igcc_pkg::MODE_LSB +: 2]);
    assign auto_md = (mode == igcc_pkg::MODE_DUAL) || (mode == igcc_pkg::MODE_SINGLE);
    assign above = st_reg.up_s[1];
    assign below = st_reg.lo_s[1];
    assign pd    = st_reg.pd_s[1];
    // programmed maximum clipped to the gain span
    assign cap = (st_reg.gain[6:0] > igcc_pkg::GAIN_MAX_CODE) ?
                 igcc_pkg::GAIN_MAX_CODE : st_reg.gain[6:0];

    // 1.28 MHz tick from a phase accumulator
    assign tick = (st_reg.ph + 17'(igcc_pkg::MOD_KHZ)) >= 17'(igcc_pkg::CLK_KHZ);
    assign take = tick && (st_reg.dec_cnt == 6'(igcc_pkg::OSR - 1));

    assign hold_lim  = st_reg.pwr[igcc_pkg::HOLD_BIT] ? HOLD_SHORT_TICKS
                                                       : HOLD_LONG_TICKS;
    assign hold_done = st_reg.hold >= hold_lim;

    // rate strobes picked from the rate registers
    assign f_att = tick && igcc_pkg::rate_hit(st_reg.presc,
                          st_reg.far[igcc_pkg::ATT_LSB +: 3]);
    assign f_rel = tick && igcc_pkg::rate_hit(st_reg.presc,
                          st_reg.far[igcc_pkg::REL_LSB +: 3]);
    assign s_att = tick && igcc_pkg::rate_hit(st_reg.presc,
                          st_reg.fmt4[igcc_pkg::ATT_LSB +: 3]);
    assign s_rel = tick && igcc_pkg::rate_hit(st_reg.presc,
                          st_reg.fmt4[igcc_pkg::REL_LSB +: 3]);

    // ****************************************************
    // gain counter steering
    // ****************************************************
    always_comb begin
        fast_if.dec    = 1'b0;
        fast_if.inc    = 1'b0;
        fast_if.load   = 1'b0;
        fast_if.target = cap;
        fast_if.max    = cap;
        slow_if.dec    = 1'b0;
        slow_if.inc    = 1'b0;
        slow_if.load   = 1'b0;
        slow_if.target = cap;
        slow_if.max    = cap;
        unique case (mode)
            igcc_pkg::MODE_DUAL, igcc_pkg::MODE_SINGLE: begin
                fast_if.dec = f_att && above;
                // release below lower threshold, capped by counter
                fast_if.inc = f_rel && below && !above && hold_done;
                if (mode == igcc_pkg::MODE_DUAL) begin
                    slow_if.dec = s_att && (slow_if.code > fast_if.code);
                    slow_if.inc = s_rel && (slow_if.code < fast_if.code);
                end
            end
            igcc_pkg::MODE_FIXED_STEP: begin
                // walk toward setting, one half-dB step per strobe
                // clamp to the full span only, else a lowered setting would jump
                fast_if.max = igcc_pkg::GAIN_MAX_CODE;
                fast_if.dec = f_att && (fast_if.code > cap);
                fast_if.inc = f_rel && (fast_if.code < cap);
            end
            igcc_pkg::MODE_FIXED_IMM: begin
                fast_if.load = 1'b1;
            end
        endcase
    end

    // dual-rate takes the smaller count; otherwise fast alone
    assign applied = (mode == igcc_pkg::MODE_DUAL) ?
                     igcc_pkg::gmin(fast_if.code, slow_if.code) : fast_if.code;

    // both counters saturate inside the counter module
    igcc_gain_ctr u_fast (
        .clk_sys (clk_sys),
        .rst     (rst),
        .clk_en  (clk_en),
        .bus     (fast_if.ctr)
    );

    igcc_gain_ctr u_slow (
        .clk_sys (clk_sys),
        .rst     (rst),
        .clk_en  (clk_en),
        .bus     (slow_if.ctr)
    );

    // dc removal on each new sample
    igcc_hpf u_hpf (
        .clk_sys    (clk_sys),
        .rst        (rst),
        .clk_en     (clk_en),
        .in_valid   (take && !pd),
        .in_sample  (adc_raw_in),
        .sel        (st_reg.fmt1[1:0]),
        .out_valid  (hpf_vld),
        .out_sample (hpf_smp)
    );

    // ****************************************************
    // next state
    // ****************************************************
    always_comb begin
        st_next      = st_reg;
        st_next.up_s = {st_reg.up_s[0], cmp_above_upper_in};
        st_next.lo_s = {st_reg.lo_s[0], cmp_below_lower_in};
        st_next.pd_s = {st_reg.pd_s[0], ext_powerdown_in};
        st_next.lb_s = {st_reg.lb_s[0], low_batt_in};
        // fractional divide: 1280 kHz out of 100 MHz
        st_next.ph = tick ? st_reg.ph + 17'(igcc_pkg::MOD_KHZ)
                            - 17'(igcc_pkg::CLK_KHZ)
                          : st_reg.ph + 17'(igcc_pkg::MOD_KHZ);
        if (tick) begin
            st_next.presc   = st_reg.presc + 16'h0001;
            st_next.dec_cnt = st_reg.dec_cnt + 6'h01;
        end
        // restart the hold timer whenever the signal comes back up
        if (!below || above) begin
            st_next.hold = '0;
        end else if (tick && !hold_done) begin
            st_next.hold = st_reg.hold + 16'h0001;
        end
        if (reg_wr) begin
            unique case (reg_addr)
                igcc_pkg::A_PWR:  st_next.pwr  = reg_wdata & igcc_pkg::PWR_MASK;
                igcc_pkg::A_GAIN: st_next.gain = reg_wdata;
                igcc_pkg::A_FAR:  st_next.far  = reg_wdata & igcc_pkg::AR_MASK;
                igcc_pkg::A_FMT1: st_next.fmt1 = reg_wdata & igcc_pkg::FMT1_MASK;
                igcc_pkg::A_FMT4: st_next.fmt4 = reg_wdata & igcc_pkg::AR_MASK;
                default: ;
            endcase
        end
        // read data stand only in the cycle after the strobe
        st_next.rdata = 8'h00;
        if (reg_rd && !pd) begin
            unique case (reg_addr)
                igcc_pkg::A_PWR:  st_next.rdata = st_reg.pwr;
                // readback of the applied gain when bit 7 is set
                igcc_pkg::A_GAIN: st_next.rdata = st_reg.gain[igcc_pkg::RDBK_BIT] ?
                                                  {1'b1, applied} : st_reg.gain;
                igcc_pkg::A_FAR:  st_next.rdata = st_reg.far;
                igcc_pkg::A_FMT1: st_next.rdata = st_reg.fmt1;
                igcc_pkg::A_FMT4: st_next.rdata = st_reg.fmt4;
                default:          st_next.rdata = 8'h00;
            endcase
        end
        // power-down holds gain, sample and valid low; reset_lowbatt_out goes high
        st_next.pd_out   = pd;
        st_next.gain_out = pd ? 7'h00 : applied;
        st_next.svld     = hpf_vld && !pd;
        st_next.smp      = pd ? 16'h0000 : (hpf_vld ? hpf_smp : st_reg.smp);
        st_next.rl_out = pd || st_reg.lb_s[1];
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            st_reg      <= '0;
            st_reg.pwr  <= igcc_pkg::PWR_RST;
            st_reg.gain <= igcc_pkg::GAIN_RST;
            st_reg.far  <= igcc_pkg::FAR_RST;
            st_reg.fmt1 <= igcc_pkg::FMT1_RST;
            st_reg.fmt4 <= igcc_pkg::FMT4_RST;
        end else if (clk_en) begin
            st_reg <= st_next;
        end
    end

    assign reg_rdata         = st_reg.rdata;
    assign gain_code_out     = st_reg.gain_out;
    assign analog_pd_out     = st_reg.pd_out;
    assign reset_lowbatt_out = st_reg.rl_out;
    assign sample_out        = st_reg.smp;
    assign sample_valid_out  = st_reg.svld;

    // ****************************************************
    // assertions
    // ****************************************************
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    property p_imm_load;
        clk_en && mode == igcc_pkg::MODE_FIXED_IMM |=> fast_if.code == $past(cap);
    endproperty
    a_imm_load: assert property (p_imm_load) else $error("immediate gain not loaded");

    property p_attack_step;
        clk_en && auto_md && f_att && above && fast_if.code != 7'h00
            && fast_if.code <= cap |=> fast_if.code == $past(fast_if.code) - 7'h01;
    endproperty
    a_attack_step: assert property (p_attack_step) else $error("attack step missing");

    property p_hold_gate;
        clk_en && auto_md && !hold_done |=> fast_if.code <= $past(fast_if.code);
    endproperty
    a_hold_gate: assert property (p_hold_gate) else $error("release before hold time");

    property p_dual_min;
        clk_en && mode == igcc_pkg::MODE_DUAL && !pd |=>
            gain_code_out == igcc_pkg::gmin($past(fast_if.code), $past(slow_if.code));
    endproperty
    a_dual_min: assert property (p_dual_min) else $error("dual gain not minimum");

    property p_single_fast;
        clk_en && mode == igcc_pkg::MODE_SINGLE && !pd |=>
            gain_code_out == $past(fast_if.code) && $stable(slow_if.code);
    endproperty
    a_single_fast: assert property (p_single_fast) else $error("single gain wrong");

    property p_fixed_dir;
        clk_en && mode == igcc_pkg::MODE_FIXED_STEP |=>
            fast_if.code <= $past(fast_if.code) + 7'h01
            && fast_if.code + 7'h01 >= $past(fast_if.code);
    endproperty
    a_fixed_dir: assert property (p_fixed_dir) else $error("fixed step skips codes");

    property p_readback;
        clk_en && reg_rd && reg_addr == igcc_pkg::A_GAIN && !pd
            && st_reg.gain[igcc_pkg::RDBK_BIT] |=> reg_rdata == {1'b1, $past(applied)};
    endproperty
    a_readback: assert property (p_readback) else $error("gain readback wrong");

    property p_unused_zero;
        clk_en && reg_rd && reg_addr == igcc_pkg::A_PWR |=>
            (reg_rdata & ~igcc_pkg::PWR_MASK) == 8'h00;
    endproperty
    a_unused_zero: assert property (p_unused_zero) else $error("unused bit reads one");

    property p_pd_low;
        clk_en && pd |=> !sample_valid_out && reg_rdata == 8'h00
            && gain_code_out == 7'h00 && analog_pd_out && reset_lowbatt_out;
    endproperty
    a_pd_low: assert property (p_pd_low) else $error("outputs not low in power-down");

    property p_code_limit;
        fast_if.code <= igcc_pkg::GAIN_MAX_CODE && slow_if.code <= igcc_pkg::GAIN_MAX_CODE;
    endproperty
    a_code_limit: assert property (p_code_limit) else $error("gain code out of range");

    c_attack: cover property (clk_en && fast_if.dec ##1 fast_if.code < 7'h52);
    c_release: cover property (clk_en && auto_md && fast_if.inc);
    c_sample: cover property (sample_valid_out);
    c_readback: cover property (reg_rd && reg_addr == igcc_pkg::A_GAIN
                                && st_reg.gain[igcc_pkg::RDBK_BIT]);
endmodule : igcc_top

// file: test/igcc_host_model.sv
`timescale 1ns/1ns
// register master standing in for the serial interface core
module igcc_host_model (
    input  wire logic       clk_sys,
    output logic      [2:0] reg_addr,
    output logic      [7:0] reg_wdata,
    output logic            reg_wr,
    output logic            reg_rd,
    input  wire logic [7:0] reg_rdata
);
    initial begin
        reg_addr = 3'h0;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
    end

    task automatic wr(input logic [2:0] a, input logic [7:0] v);
        @(posedge clk_sys);
        reg_addr  <= a;
        reg_wdata <= v;
        reg_wr    <= 1'b1;
        @(posedge clk_sys);
        reg_wr    <= 1'b0;
        reg_wdata <= ~v; // released data must not look valid
    endtask : wr

    // read word; data stands only in the cycle after the strobe
    task automatic rd(input logic [2:0] a, output logic [7:0] v);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk_sys);
        reg_rd   <= 1'b0;
        #1;
        v = reg_rdata;
    endtask : rd
endmodule : igcc_host_model

// file: test/tb_igcc_top.sv
`timescale 1ns/1ns
module tb_igcc_top;
    logic        clk_sys = 1'b0;
    logic        rst = 1'b1;
    logic [2:0]  reg_addr;
    logic [7:0]  reg_wdata, reg_rdata, d;
    logic        reg_wr, reg_rd, apd, rlb, sv;
    logic        cmp_up = 1'b0, cmp_lo = 1'b0, pd = 1'b0, lb = 1'b0, en = 1'b1;
    logic [15:0] adc = 16'h0000, smp;
    logic [6:0]  gain, t, t2;
    logic [31:0] rnd = 32'h60655D7E;
    int          n_mismatch = 0;
    int          compares = 0;
    int          k;
    logic [7:0]  rst_tab [8] = '{8'h00, igcc_pkg::PWR_RST, igcc_pkg::GAIN_RST,
        igcc_pkg::FAR_RST, igcc_pkg::FMT1_RST, igcc_pkg::FMT4_RST, 8'h00, 8'h00};
    logic [7:0]  msk_tab [8] = '{8'h00, igcc_pkg::PWR_MASK, 8'hFF, igcc_pkg::AR_MASK,
        igcc_pkg::FMT1_MASK, igcc_pkg::AR_MASK, 8'h00, 8'h00};

    always #5 clk_sys = ~clk_sys;

    igcc_host_model host (.clk_sys(clk_sys), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
                          .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));

    // short hold counts keep the release checks inside the run budget
    igcc_top #(.HOLD_LONG_TICKS(16'h0028), .HOLD_SHORT_TICKS(16'h0014)) uut (
        .clk_sys(clk_sys), .rst(rst), .clk_en(en), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .cmp_above_upper_in(cmp_up), .cmp_below_lower_in(cmp_lo),
        .ext_powerdown_in(pd), .low_batt_in(lb), .adc_raw_in(adc),
        .gain_code_out(gain), .analog_pd_out(apd), .reset_lowbatt_out(rlb),
        .sample_out(smp), .sample_valid_out(sv));

    // ****************************************
    // helpers
    // ****************************************
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr

    task automatic give_verdict();
        $display("compares %0d n_mismatch %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : give_verdict

    task automatic chk(input string what, input logic [15:0] e, input logic [15:0] g);
        compares++;
        if (g !== e) begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", what, e, g);
        end
    endtask : chk

    task automatic rchk(input logic [2:0] a, input logic [7:0] e);
        host.rd(a, d);
        chk("reg_rdata", {8'h00, e}, {8'h00, d});
    endtask : rchk

    // waits for a gain code; stepped walks may move one code per cycle at most
    task automatic wait_gain(input logic [6:0] e, input int bound, input logic stepped);
        logic [6:0] prev;
        prev = gain;
        for (k = 0; k < bound && gain !== e; k++) begin
            @(posedge clk_sys);
            #1;
            if (stepped && (gain > prev + 7'h01 || prev > gain + 7'h01))
                chk("gain_step", {9'h000, prev}, {9'h000, gain});
            prev = gain;
        end
        chk("gain_code_out", {9'h000, e}, {9'h000, gain});
        if (gain !== e) give_verdict();
    endtask : wait_gain

    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        repeat (16) @(posedge clk_sys);
        rst <= 1'b0;
        for (int a = 0; a < 8; a++) rchk(3'(a), rst_tab[a]);
        chk("gain_reset", 16'h0052, {9'h000, gain});
        for (int a = 0; a < 8; a++) begin
            if (a == 2) continue;
            host.wr(3'(a), 8'hFF);
            rchk(3'(a), msk_tab[a]);
        end
        repeat (3) begin
            rnd = lfsr(rnd);
            t = 7'h08 + 7'(rnd[15:0] % 16'h0040);
            host.wr(igcc_pkg::A_GAIN, {1'b0, t});
            wait_gain(t, 4, 1'b0);
        end
        t2 = t + 7'h06;
        host.wr(igcc_pkg::A_FAR, 8'h00);
        host.wr(igcc_pkg::A_PWR, 8'h08);
        host.wr(igcc_pkg::A_GAIN, {1'b0, t2});
        wait_gain(t2, 4500, 1'b1);
        chk("step_slow", 16'h0001, {15'h0000, k >= 3000});
        // stepping down must pass every code as well
        host.wr(igcc_pkg::A_GAIN, {1'b0, t});
        wait_gain(t, 4500, 1'b1);
        // mode first, so the fixed walk never sees the raised setting
        host.wr(igcc_pkg::A_PWR, 8'h14);
        host.wr(igcc_pkg::A_GAIN, 8'hD2);
        @(posedge clk_sys);
        cmp_up <= 1'b1;
        wait_gain(t - 7'h02, 1500, 1'b1);
        cmp_up <= 1'b0;
        rchk(igcc_pkg::A_GAIN, {1'b1, t - 7'h02});
        @(posedge clk_sys);
        cmp_lo <= 1'b1;
        repeat (1400) @(posedge clk_sys);
        #1;
        chk("gain_hold", {9'h000, t - 7'h02}, {9'h000, gain});
        wait_gain(7'h52, 52000, 1'b1);
        repeat (1300) @(posedge clk_sys);
        #1;
        chk("gain_cap", 16'h0052, {9'h000, gain});
        @(posedge clk_sys);
        cmp_lo <= 1'b0;
        rnd = lfsr(rnd);
        adc <= rnd[15:0];
        for (k = 0; k < 6000 && sv !== 1'b1; k++) begin
            @(posedge clk_sys);
            #1;
        end
        for (k = 1; k < 6000; k++) begin
            @(posedge clk_sys);
            #1;
            if (k == 1) chk("valid_pulse", 16'h0000, {15'h0000, sv});
            // 100 frozen cycles stretch the sample period by as many
            if (k == 10) en <= 1'b0;
            if (k == 110) en <= 1'b1;
            if (sv === 1'b1) break;
        end
        chk("sample_period", 16'h13EC, 16'(k));
        chk("sample_out", adc, smp);
        @(posedge clk_sys);
        pd <= 1'b1;
        repeat (4) @(posedge clk_sys);
        #1;
        chk("pd_state", 16'h0003, {14'h0000, apd, rlb});
        chk("pd_sample", 16'h0000, smp);
        rchk(igcc_pkg::A_PWR, 8'h00);
        @(posedge clk_sys);
        pd <= 1'b0;
        lb <= 1'b1;
        repeat (4) @(posedge clk_sys);
        #1;
        chk("lowbatt", 16'h0001, {14'h0000, apd, rlb});
        give_verdict();
    end
endmodule : tb_igcc_top
